// [rtl/opaddr_pkg.sv]
/*
  Shared constants and types for the operand addressing block: operation
  encodings, addressing forms, targets, field sizes and reset values.
  Assumes an 8-bit core with an external byte-wide data memory port.
*/
package opaddr_pkg;

  localparam int unsigned W           = 8;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [7:0]  RST_STATUS  = 8'h02;
  localparam logic [15:0] RST_PC      = 16'h0000;
  localparam int unsigned BANK_BIT    = 4;
  localparam logic [1:0]  LEN_ONE     = 2'h1;
  localparam logic [1:0]  LEN_TWO     = 2'h2;
  localparam logic [1:0]  LEN_THREE   = 2'h3;

  typedef enum logic [2:0] {
    OP_ADD, OP_AND, OP_OR, OP_XOR, OP_MOV
  } alu_op_e;

  typedef enum logic [2:0] {
    FORM_SRC_IMM, FORM_SRC_DIR, FORM_SRC_IDX, FORM_DST_DIR, FORM_DST_IDX, FORM_DST_DIR_IMM, FORM_NONE
  } form_e;

  typedef enum logic [1:0] {
    TGT_SUM, TGT_STATUS, TGT_STACK, TGT_OFFSET
  } target_e;

  // Decoded instruction
  typedef struct packed {
    form_e      form;
    alu_op_e    op;
    target_e    tgt;
    logic       reg_space;
    logic [1:0] len;
  } dec_s;

  // Memory request toward RAM or a register bank
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       reg_space;
    logic       bank;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mem_req_s;

endpackage

// [rtl/opaddr_decode.sv]
/*
  Opcode decoder: maps an opcode byte to addressing form, operation,
  target register, address space and instruction length.
  Purely combinational; fed by the fetch sequencer in opaddr_core.
*/
`timescale 1ns/1ps
module opaddr_decode
  import opaddr_pkg::*;
(
  input  wire logic [7:0]     opcode_i,
  output opaddr_pkg::dec_s    dec_o
);

  import opaddr_pkg::*;

  // Length is filled in after the table, from the form alone
  function automatic dec_s dec_entry(input form_e f, input alu_op_e o, input target_e t, input logic rs);
    return '{form: f, op: o, tgt: t, reg_space: rs, len: LEN_ONE};
  endfunction

  always_comb
  begin
    // Space comes from the opcode only, never from the operand [RQ12]
    case (opcode_i)
      8'h01:   dec_o = dec_entry(FORM_SRC_IMM,     OP_ADD, TGT_SUM,    1'b0);
      8'h02:   dec_o = dec_entry(FORM_SRC_DIR,     OP_ADD, TGT_SUM,    1'b0);
      8'h03:   dec_o = dec_entry(FORM_SRC_IDX,     OP_ADD, TGT_SUM,    1'b0);
      8'h04:   dec_o = dec_entry(FORM_DST_DIR,     OP_ADD, TGT_SUM,    1'b0);
      8'h05:   dec_o = dec_entry(FORM_DST_IDX,     OP_ADD, TGT_SUM,    1'b0);
      8'h06:   dec_o = dec_entry(FORM_DST_DIR_IMM, OP_ADD, TGT_SUM,    1'b0);
      8'h31:   dec_o = dec_entry(FORM_SRC_IMM,     OP_XOR, TGT_SUM,    1'b0);
      8'h32:   dec_o = dec_entry(FORM_SRC_DIR,     OP_XOR, TGT_SUM,    1'b0);
      8'h34:   dec_o = dec_entry(FORM_DST_DIR,     OP_XOR, TGT_SUM,    1'b0);
      8'h36:   dec_o = dec_entry(FORM_DST_DIR_IMM, OP_XOR, TGT_SUM,    1'b0);
      8'h2E:   dec_o = dec_entry(FORM_DST_DIR_IMM, OP_OR,  TGT_SUM,    1'b0);
      8'h70:   dec_o = dec_entry(FORM_SRC_IMM,     OP_AND, TGT_STATUS, 1'b0);
      8'h71:   dec_o = dec_entry(FORM_SRC_IMM,     OP_OR,  TGT_STATUS, 1'b0);
      8'h38:   dec_o = dec_entry(FORM_SRC_IMM,     OP_ADD, TGT_STACK,  1'b0);
      8'h50:   dec_o = dec_entry(FORM_SRC_IMM,     OP_MOV, TGT_SUM,    1'b0);
      8'h57:   dec_o = dec_entry(FORM_SRC_IMM,     OP_MOV, TGT_OFFSET, 1'b0);
      8'h51:   dec_o = dec_entry(FORM_SRC_DIR,     OP_MOV, TGT_SUM,    1'b0);
      8'h52:   dec_o = dec_entry(FORM_SRC_IDX,     OP_MOV, TGT_SUM,    1'b0);
      8'h58:   dec_o = dec_entry(FORM_SRC_DIR,     OP_MOV, TGT_OFFSET, 1'b0);
      8'h59:   dec_o = dec_entry(FORM_SRC_IDX,     OP_MOV, TGT_OFFSET, 1'b0);
      8'h5D:   dec_o = dec_entry(FORM_SRC_DIR,     OP_MOV, TGT_SUM,    1'b1);
      8'h5E:   dec_o = dec_entry(FORM_SRC_IDX,     OP_MOV, TGT_SUM,    1'b1);
      8'h53:   dec_o = dec_entry(FORM_DST_DIR,     OP_MOV, TGT_SUM,    1'b0);
      8'h54:   dec_o = dec_entry(FORM_DST_IDX,     OP_MOV, TGT_SUM,    1'b0);
      8'h5A:   dec_o = dec_entry(FORM_DST_DIR,     OP_MOV, TGT_OFFSET, 1'b0);
      8'h60:   dec_o = dec_entry(FORM_DST_DIR,     OP_MOV, TGT_SUM,    1'b1);
      8'h61:   dec_o = dec_entry(FORM_DST_IDX,     OP_MOV, TGT_SUM,    1'b1);
      8'h55:   dec_o = dec_entry(FORM_DST_DIR_IMM, OP_MOV, TGT_SUM,    1'b0);
      8'h62:   dec_o = dec_entry(FORM_DST_DIR_IMM, OP_MOV, TGT_SUM,    1'b1);
      default: dec_o = dec_entry(FORM_NONE,        OP_MOV, TGT_SUM,    1'b0);
    endcase
    case (dec_o.form)
      FORM_NONE:        dec_o.len = LEN_ONE;
      FORM_DST_DIR_IMM: dec_o.len = LEN_THREE;  // [RQ9]
      default:          dec_o.len = LEN_TWO;
    endcase
  end

endmodule

// [rtl/opaddr_core.sv]
/*
  Operand addressing sequencer of an 8-bit core. Fetches opcode and
  operand bytes, resolves immediate, direct, indexed and direct-plus-
  immediate operands, reads and writes RAM or register space, and holds
  the working registers.
  Assumes code and data ports answer within the same cycle as a request and
  that unknown opcodes are skipped as one-byte no-ops.
*/
// Operation
// (RQ1) Immediate source into sum, status, stack or offset
// (RQ2) AND immediate into status combines with status
// (RQ3) Direct source address read, two bytes
// (RQ4) Indexed source address is operand plus offset
// (RQ5) Direct destination written from sum or offset
// (RQ6) Indexed destination written from sum register
// (RQ7) Memory destination leaves sum register unchanged
// (RQ8) Second operand byte immediate, first is destination
// (RQ9) Direct-immediate instructions are three bytes long
// (RQ10) Register space steered by bank select bit
// (RQ11) Offset register is eight bits wide
// (RQ12) Space chosen from opcode, not operand value
// (RQ13) Moves never read destination as source
`timescale 1ns/1ps
module opaddr_core
  import opaddr_pkg::*;
(
  input  wire logic                 core_clk_i,
  input  wire logic                 rstn_i,
  output logic [15:0]               code_addr_o,
  output logic                      code_rd_o,
  input  wire logic [7:0]           code_data_i,
  output opaddr_pkg::mem_req_s      mem_req_o,
  input  wire logic [7:0]           mem_rdata_i,
  output logic [7:0]                sum_holder_o,
  output logic [7:0]                offset_reg_o,
  output logic [7:0]                stack_top_ptr_o,
  output logic [7:0]                status_word_o,
  output logic                      instr_done_o
);

  import opaddr_pkg::*;

  typedef enum logic [2:0] {
    S_OPC, S_OPND1, S_OPND2, S_READ, S_EXEC
  } state_e;

  state_e      state_q;
  logic [15:0] pc_q;
  logic [7:0]  opc_q;
  logic [7:0]  opnd1_q;
  logic [7:0]  opnd2_q;
  logic [7:0]  sum_q;
  logic [7:0]  offset_q;   // [RQ11]
  logic [7:0]  stack_q;
  logic [7:0]  status_q;
  logic        done_q;
  mem_req_s    req_q;
  dec_s        dec;
  logic [7:0]  ea;
  logic [7:0]  src_reg;
  logic [7:0]  result;
  logic        is_dst;

  opaddr_decode u_dec (
    .opcode_i (opc_q),
    .dec_o    (dec)
  );

  function automatic logic [7:0] alu(input alu_op_e op, input logic [7:0] a, input logic [7:0] b);
    case (op)
      OP_ADD:  alu = 8'(a + b);
      OP_AND:  alu = a & b;
      OP_OR:   alu = a | b;
      OP_XOR:  alu = a ^ b;
      default: alu = b;
    endcase
  endfunction

  // Indexed forms add the offset register, wrapping within one page
  always_comb
  begin
    case (dec.form)
      FORM_SRC_IDX, FORM_DST_IDX: ea = 8'(opnd1_q + offset_q);  // [RQ4] [RQ6]
      default:                    ea = opnd1_q;                 // [RQ3] [RQ5] [RQ8]
    endcase
  end

  assign is_dst  = (dec.form == FORM_DST_DIR) || (dec.form == FORM_DST_IDX) || (dec.form == FORM_DST_DIR_IMM);
  assign src_reg = (dec.tgt == TGT_OFFSET) ? offset_q : sum_q;

  // Result for the execute cycle; moves pass the source through untouched
  always_comb
  begin
    case (dec.form)
      FORM_SRC_IMM:
        case (dec.tgt)
          TGT_STATUS: result = alu(dec.op, status_q, opnd1_q);  // [RQ2]
          TGT_STACK:  result = alu(dec.op, stack_q, opnd1_q);
          TGT_OFFSET: result = alu(dec.op, offset_q, opnd1_q);
          default:    result = alu(dec.op, sum_q, opnd1_q);     // [RQ1]
        endcase
      FORM_SRC_DIR, FORM_SRC_IDX: result = alu(dec.op, src_reg, mem_rdata_i);  // [RQ3] [RQ4]
      FORM_DST_DIR:               result = alu(dec.op, mem_rdata_i, src_reg);  // [RQ5] [RQ13]
      FORM_DST_IDX:               result = alu(dec.op, mem_rdata_i, sum_q);    // [RQ6] [RQ13]
      FORM_DST_DIR_IMM:           result = alu(dec.op, mem_rdata_i, opnd2_q);  // [RQ8] [RQ13]
      default:                    result = RST_BYTE;
    endcase
  end

  assign code_addr_o = pc_q;
  assign code_rd_o   = (state_q == S_OPC) || (state_q == S_OPND1) || (state_q == S_OPND2);

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      state_q <= S_OPC;
    else
      case (state_q)
        S_OPC:   state_q <= S_OPND1;
        S_OPND1:
          if (dec.form == FORM_NONE)
            state_q <= S_OPC;
          else if (dec.len == LEN_THREE)
            state_q <= S_OPND2;  // [RQ9]
          else if (dec.form == FORM_SRC_IMM)
            state_q <= S_EXEC;
          else
            state_q <= S_READ;
        S_OPND2: state_q <= S_READ;
        S_READ:  state_q <= S_EXEC;
        S_EXEC:  state_q <= S_OPC;
        default: state_q <= S_OPC;
      endcase
  end

  // Opcode byte is captured at the end of the cycle in which S_OPC presents the address
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      pc_q    <= RST_PC;
      opc_q   <= RST_BYTE;
      opnd1_q <= RST_BYTE;
      opnd2_q <= RST_BYTE;
    end
    else
      case (state_q)
        S_OPC:
        begin
          opc_q <= code_data_i;
          pc_q  <= 16'(pc_q + 16'h0001);
        end
        S_OPND1:
          if (dec.form != FORM_NONE)
          begin
            opnd1_q <= code_data_i;
            pc_q    <= 16'(pc_q + 16'h0001);
          end
        S_OPND2:
        begin
          opnd2_q <= code_data_i;
          pc_q    <= 16'(pc_q + 16'h0001);
        end
        default: pc_q <= pc_q;
      endcase
  end

  // Unknown opcodes peek at the next byte but leave it for the next fetch
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      req_q <= '0;
    else
    begin
      req_q           <= '0;
      req_q.reg_space <= dec.reg_space;          // [RQ12]
      req_q.bank      <= status_q[BANK_BIT];     // [RQ10]
      req_q.addr      <= ea;
      if (state_q == S_READ && !(is_dst && dec.op == OP_MOV))
        req_q.rd <= 1'b1;                        // [RQ13]
      if (state_q == S_EXEC && is_dst)
      begin
        req_q.wr    <= 1'b1;                     // [RQ5] [RQ6] [RQ8]
        req_q.wdata <= result;
      end
    end
  end

  assign mem_req_o = req_q;

  // Working registers; memory destinations never touch sum_q
  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      sum_q    <= RST_BYTE;
      offset_q <= RST_BYTE;
      stack_q  <= RST_BYTE;
      status_q <= RST_STATUS;
    end
    else if (state_q == S_EXEC && !is_dst)  // [RQ7]
      case (dec.tgt)
        TGT_STATUS: status_q <= result;     // [RQ2]
        TGT_STACK:  stack_q  <= result;     // [RQ1]
        TGT_OFFSET: offset_q <= result;     // [RQ1] [RQ3] [RQ4]
        default:    sum_q    <= result;     // [RQ1] [RQ3] [RQ4]
      endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
      done_q <= 1'b0;
    else
      done_q <= (state_q == S_EXEC) || (state_q == S_OPND1 && dec.form == FORM_NONE);
  end

  assign sum_holder_o    = sum_q;
  assign offset_reg_o    = offset_q;
  assign stack_top_ptr_o = stack_q;
  assign status_word_o   = status_q;
  assign instr_done_o    = done_q;

endmodule

// [dv/opaddr_core_props.sv]
/*
  Port checker for opaddr_core, bound to every instance.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module opaddr_core_chk
  import opaddr_pkg::*;
(
  input wire logic                 core_clk_i,
  input wire logic                 rstn_i,
  input wire logic [15:0]          code_addr_o,
  input wire logic                 code_rd_o,
  input wire logic [7:0]           code_data_i,
  input wire opaddr_pkg::mem_req_s mem_req_o,
  input wire logic [7:0]           mem_rdata_i,
  input wire logic [7:0]           sum_holder_o,
  input wire logic [7:0]           offset_reg_o,
  input wire logic [7:0]           stack_top_ptr_o,
  input wire logic [7:0]           status_word_o,
  input wire logic                 instr_done_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  AST_RD_DONE: assert property (mem_req_o.rd |=> instr_done_o && !mem_req_o.rd)
    else $error("read not followed by completion");
  AST_WR_DONE: assert property (mem_req_o.wr |-> instr_done_o && !$past(mem_req_o.wr))
    else $error("write outside completion cycle");
  AST_SUM_KEEP: assert property (mem_req_o.wr |-> $stable(sum_holder_o))
    else $error("sum changed by memory write");
  AST_BANK: assert property ((mem_req_o.rd || mem_req_o.wr) && mem_req_o.reg_space |->
    mem_req_o.bank == status_word_o[BANK_BIT])
    else $error("bank differs from status bit");
  // An undecoded opcode ends at once and leaves the byte it peeked at for the next fetch
  AST_PC_STEP: assert property (code_rd_o |=>
    (instr_done_o ? $stable(code_addr_o) : code_addr_o == 16'($past(code_addr_o) + 16'h0001)))
    else $error("fetch did not advance pc");
  AST_PC_HOLD: assert property (!code_rd_o |=> $stable(code_addr_o))
    else $error("pc moved without fetch");
  AST_SP_SRC: assert property ($changed(stack_top_ptr_o) |-> instr_done_o && !$past(mem_req_o.rd))
    else $error("stack pointer changed unexpectedly");
  AST_ST_SRC: assert property ($changed(status_word_o) |-> instr_done_o && !$past(mem_req_o.rd))
    else $error("status changed unexpectedly");
  AST_OFS: assert property ($changed(offset_reg_o) |-> instr_done_o && !mem_req_o.wr)
    else $error("offset changed unexpectedly");
  AST_NO_FETCH_RD: assert property (mem_req_o.rd |-> !code_rd_o)
    else $error("fetch during operand read");

  COV_REG_WR: cover property (mem_req_o.wr && mem_req_o.reg_space);
  COV_BANK1: cover property (mem_req_o.rd && mem_req_o.reg_space && mem_req_o.bank);
  COV_ST: cover property ($changed(status_word_o));
endmodule

bind opaddr_core opaddr_core_chk opaddr_core_chk_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i),
  .code_addr_o(code_addr_o), .code_rd_o(code_rd_o), .code_data_i(code_data_i), .mem_req_o(mem_req_o),
  .mem_rdata_i(mem_rdata_i), .sum_holder_o(sum_holder_o), .offset_reg_o(offset_reg_o),
  .stack_top_ptr_o(stack_top_ptr_o), .status_word_o(status_word_o), .instr_done_o(instr_done_o));

// [dv/tb_top.sv]
/*
  Self-checking bench for opaddr_core: every decoded opcode and undecoded FF once, then random code.
  Assumes the checker binds itself to opaddr_core.
*/
`timescale 1ns/1ps
module tb_top;
  import opaddr_pkg::*;
  typedef struct {logic [7:0] a, x, sp, f, wa, wd; logic wr, rs, bk, rd; logic [15:0] pc;} exp_s;
  // Entry: opcode, form (6: undecoded nop), operation (add and or xor mov), register (+8 for register space)
  localparam logic [19:0] TBL [30] = '{20'h01000, 20'h02100, 20'h03200, 20'h04300, 20'h05400, 20'h06500,
    20'h31030, 20'h32130, 20'h34330, 20'h36530, 20'h2E520, 20'h70011, 20'h71021, 20'h38002, 20'h50040,
    20'h57043, 20'h51140, 20'h52240, 20'h58143, 20'h59243, 20'h5D148, 20'h5E248, 20'h53340, 20'h54440,
    20'h5A343, 20'h60348, 20'h61448, 20'h55540, 20'h62548, 20'hFF600};
  logic        core_clk_i;
  logic        rstn_i;
  logic [15:0] code_addr_o;
  logic        code_rd_o;
  logic [7:0]  code_data_i = 8'h00;
  mem_req_s    mem_req_o;
  logic [7:0]  mem_rdata_i = 8'h00;
  logic [7:0]  sum_holder_o, offset_reg_o, stack_top_ptr_o, status_word_o;
  logic        instr_done_o;
  logic [7:0]  rom [1024];
  logic [7:0]  mem [768];
  logic [7:0]  sm [768];
  logic [7:0]  a, x, sp, f;
  logic        rd_seen = 1'b0;
  exp_s        q [$];
  exp_s        ce;
  int          pc, cyc, error_cnt, tests_run;

  opaddr_core opaddr_core_inst (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .code_addr_o(code_addr_o),
    .code_rd_o(code_rd_o), .code_data_i(code_data_i), .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata_i),
    .sum_holder_o(sum_holder_o), .offset_reg_o(offset_reg_o), .stack_top_ptr_o(stack_top_ptr_o),
    .status_word_o(status_word_o), .instr_done_o(instr_done_o));

  // RAM at 0..255, register bank 0 and 1 above it
  function automatic int ix(input logic rs, input logic bk, input logic [7:0] ad);
    return rs ? 256 + int'({bk, ad}) : int'(ad);
  endfunction

  task automatic miss(input string m);
    error_cnt++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic end_sim();
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic gen(input logic [19:0] t);
    logic [7:0] b1, b2, ad, sv, ov, sec, r;
    logic [3:0] fm, al, tg;
    int k;
    exp_s e;
    {b1, b2} = 16'($urandom);
    {fm, al, tg} = t[11:0];
    rom[pc] = t[19:12];
    if (fm != 4'h6) rom[pc+1] = b1;
    if (fm == 4'h5) rom[pc+2] = b2;
    pc += (fm == 4'h5) ? 3 : (fm == 4'h6) ? 1 : 2;
    ad = (fm == 4'h2 || fm == 4'h4) ? b1 + x : b1;
    k = ix(tg[3], f[BANK_BIT], ad);
    case (tg[1:0]) 2'h0: sv = a; 2'h1: sv = f; 2'h2: sv = sp; default: sv = x; endcase
    ov = (fm == 4'h0) ? b1 : (fm == 4'h5) ? b2 : (fm < 4'h3) ? sm[k] : sv;
    sec = (fm < 4'h3) ? sv : sm[k];
    case (al) 4'h0: r = ov + sec; 4'h1: r = ov & sec; 4'h2: r = ov | sec; 4'h3: r = ov ^ sec; default: r = ov; endcase
    e.rd = (fm == 4'h1 || fm == 4'h2) || (fm > 4'h2 && fm < 4'h6 && al != 4'h4);
    e.wr = fm > 4'h2 && fm < 4'h6;
    {e.wa, e.wd, e.rs, e.bk} = {ad, r, tg[3], f[BANK_BIT]};
    if (e.wr) sm[k] = r;
    else if (fm != 4'h6) case (tg[1:0]) 2'h0: a = r; 2'h1: f = r; 2'h2: sp = r; default: x = r; endcase
    {e.a, e.x, e.sp, e.f, e.pc} = {a, x, sp, f, 16'(pc)};
    q.push_back(e);
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  always @(negedge core_clk_i)
  begin
    code_data_i <= rom[code_addr_o[9:0]];
    mem_rdata_i <= mem[ix(mem_req_o.reg_space, mem_req_o.bank, mem_req_o.addr)];
  end

  always @(posedge core_clk_i)
  begin
    if (mem_req_o.wr === 1'b1) mem[ix(mem_req_o.reg_space, mem_req_o.bank, mem_req_o.addr)] <= mem_req_o.wdata;
    if (mem_req_o.rd === 1'b1) rd_seen <= 1'b1;
    if (instr_done_o === 1'b1 && q.size() > 0)
    begin
      ce = q.pop_front();
      tests_run++;
      if ({sum_holder_o, offset_reg_o, stack_top_ptr_o, status_word_o} !== {ce.a, ce.x, ce.sp, ce.f})
        miss("register mismatch");
      if ({code_addr_o, code_rd_o} !== {ce.pc, 1'b1}) miss("pc or fetch mismatch");
      if (mem_req_o.wr !== ce.wr) miss("write presence mismatch");
      if (ce.wr && {mem_req_o.addr, mem_req_o.wdata} !== {ce.wa, ce.wd})
        miss("write address or data mismatch");
      if (ce.wr && {mem_req_o.reg_space, mem_req_o.bank} !== {ce.rs, ce.bk})
        miss("write space or bank mismatch");
      if (rd_seen !== ce.rd) miss("read presence mismatch");
      rd_seen <= 1'b0;
    end
    cyc++;
    if (cyc > 4000)
    begin
      miss("timeout");
      end_sim();
    end
  end

  initial
  begin
    void'($urandom(32'hF24E));
    {rstn_i, pc} = '0;
    {a, x, sp, f} = {RST_BYTE, RST_BYTE, RST_BYTE, RST_STATUS};
    foreach (rom[i]) rom[i] = 8'hFF;
    foreach (mem[i])
    begin
      mem[i] = 8'($urandom);
      sm[i] = mem[i];
    end
    for (int i = 0; i < 300; i++) gen(TBL[i < 30 ? i : $urandom_range(29)]);
    repeat (20) @(negedge core_clk_i);
    rstn_i = 1'b1;
    wait (q.size() == 0);
    repeat (2) @(negedge core_clk_i);
    end_sim();
  end
endmodule
